// *** mem_block_consts.svh ***
// Contract
// - The block stores 256 words of 9 bits.
// - The block has one write port and one read port that work independently of each other.
// - Each instance works either as a random-access memory or as a first-in first-out queue.
// - The read port and the write port can each be set to synchronous or asynchronous.
// - Queue mode has programmable flag levels and a selectable depth.
// - Parity can optionally be generated on written data and checked on read data.
// - One block on its own runs at clock rates up to 133 MHz.
// - Blocks can be placed side by side to widen the word, with any width up to 252.
// - For a width that is not a multiple of 9, the unused bit columns are not usable by any other memory.
// - Blocks can be stacked in steps of 256 words, to a depth of up to 7168 words.
// - A block works either on its own or joined with other blocks into a larger memory.
// - A synchronous read port can be set to pipelined (one extra cycle) or to transparent.
`ifndef MEM_BLOCK_CONSTS_SVH
`define MEM_BLOCK_CONSTS_SVH
`define MEM_AW       8
`define MEM_DW       9
`define MEM_WORDS    256
`define MEM_HIW      5
`define CNT_W        9
`define APB_AW       12
`define REG_CTRL     12'h000
`define REG_DEPTH    12'h004
`define REG_THRESH   12'h008
`define REG_COLMASK  12'h00C
`define REG_STATUS   12'h010
`define REG_IRQ_STAT 12'h014
`define REG_IRQ_MASK 12'h018
`define CTRL_W       13
`define CTRL_WMASK   13'h1F7F
`define CTRL_FIFO    0
`define CTRL_WRSYNC  1
`define CTRL_RDSYNC  2
`define CTRL_RDPIPE  3
`define CTRL_PAREN   4
`define CTRL_PARODD  5
`define CTRL_CASC    6
`define CTRL_ID_LO   8
`define CTRL_ID_HI   12
`define CTRL_RST     13'h0000
`define DEPTH_RST    8'hFF
`define AE_RST       8'h01
`define AF_RST       8'hFF
`define COLMASK_RST  9'h1FF
`define PAR_BIT      8
`define IRQ_W        3
`define IRQ_PARITY   0
`define IRQ_OVER     1
`define IRQ_UNDER    2
`define IRQ_RST      3'h0
`endif

// *** mem_block_pkg.sv ***
package mem_block_pkg;
  typedef logic [8:0] word_t;
  typedef logic [7:0] addr_t;
  typedef enum logic {MODE_SRAM, MODE_FIFO} mode_e;
endpackage

// *** mem_port_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface mem_port_if;
  logic                 wrEn;
  mem_block_pkg::addr_t wrAddr;
  mem_block_pkg::word_t wrData;
  logic                 rdEn;
  mem_block_pkg::addr_t rdAddr;
  mem_block_pkg::word_t rdData;
  modport ctrl (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr,
                input rdData);
  modport ram  (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr,
                output rdData);
endinterface
`default_nettype wire

// *** ram_256x9.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module ram_256x9 (
  input  wire logic clk,     // System clock
  input  wire logic resetn,  // Async reset, active low
  mem_port_if.ram   port     // Write and read port
);
  mem_block_pkg::word_t mem [0:`MEM_WORDS-1];
  mem_block_pkg::word_t rdData_q;
  mem_block_pkg::word_t rdData_d;

  // Independent ports, old data on same-address collision
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_comb begin
    rdData_d = port.rdEn ? mem[port.rdAddr] : rdData_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign port.rdData = rdData_q;
endmodule
`default_nettype wire

// *** fifo_level.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module fifo_level (
  input  wire logic             clk,          // System clock
  input  wire logic             resetn,       // Async reset, active low
  input  wire logic             clear,        // Empty the queue
  input  wire logic             push,         // Write attempt
  input  wire logic             pop,          // Read attempt
  input  wire logic [`MEM_AW-1:0] depthM1,    // Depth minus one
  input  wire logic [`MEM_AW-1:0] aeLvl,      // Almost-empty level
  input  wire logic [`MEM_AW-1:0] afLvl,      // Almost-full level
  output logic                  pushOk,       // Write accepted
  output logic                  popOk,        // Read accepted
  output logic [`MEM_AW-1:0]    wrPtr,        // Write pointer
  output logic [`MEM_AW-1:0]    rdPtr,        // Read pointer
  output logic [`CNT_W-1:0]     count,        // Words held
  output logic                  empty,        // No words
  output logic                  full,         // Depth reached
  output logic                  almostEmpty,  // Count at or below level
  output logic                  almostFull    // Count at or above level
);
  logic [`MEM_AW-1:0] wrPtr_d;
  logic [`MEM_AW-1:0] rdPtr_d;
  logic [`CNT_W-1:0]  count_d;
  logic [`CNT_W-1:0]  depth;

  function automatic logic [`MEM_AW-1:0] nextPtr(input logic [`MEM_AW-1:0] p,
                                                 input logic [`MEM_AW-1:0] last);
    nextPtr = (p == last) ? '0 : `MEM_AW'(p + 1'b1);
  endfunction

  always_comb begin
    depth   = `CNT_W'({1'b0, depthM1} + 1'b1);
    pushOk  = push & (count < depth);
    popOk   = pop & (count != '0);
    wrPtr_d = wrPtr;
    rdPtr_d = rdPtr;
    count_d = count;
    if (clear) begin
      wrPtr_d = '0;
      rdPtr_d = '0;
      count_d = '0;
    end else begin
      if (pushOk) begin
        wrPtr_d = nextPtr(wrPtr, depthM1);
      end
      if (popOk) begin
        rdPtr_d = nextPtr(rdPtr, depthM1);
      end
      if (pushOk & ~popOk) begin
        count_d = `CNT_W'(count + 1'b1);
      end else if (popOk & ~pushOk) begin
        count_d = `CNT_W'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr       <= '0;
      rdPtr       <= '0;
      count       <= '0;
      empty       <= 1'b1;
      full        <= 1'b0;
      almostEmpty <= 1'b1;
      almostFull  <= 1'b0;
    end else begin
      wrPtr       <= wrPtr_d;
      rdPtr       <= rdPtr_d;
      count       <= count_d;
      empty       <= (count_d == '0);
      full        <= (count_d >= depth);
      almostEmpty <= (count_d <= {1'b0, aeLvl});
      almostFull  <= (count_d >= {1'b0, afLvl});
    end
  end
endmodule
`default_nettype wire

// *** mem_block.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mem_block (
  input  wire logic                sys_clk,          // System clock
  input  wire logic                resetn,           // Async reset, active low
  input  wire logic                psel,             // APB select
  input  wire logic                penable,          // APB enable
  input  wire logic                pwrite,           // APB direction
  input  wire logic [`APB_AW-1:0]  paddr,            // APB byte address
  input  wire logic [31:0]         pwdata,           // APB write data
  output logic [31:0]              prdata,           // APB read data
  output logic                     pready,           // APB ready
  output logic                     pslverr,          // APB error
  input  wire logic                wrEn,             // Write request
  input  wire logic [`MEM_AW-1:0]  wrAddr,           // Write word address
  input  wire logic [`MEM_HIW-1:0] wrAddrHi,         // Write block select
  input  wire logic [`MEM_DW-1:0]  wrData,           // Write data
  input  wire logic                rdEn,             // Read request
  input  wire logic [`MEM_AW-1:0]  rdAddr,           // Read word address
  input  wire logic [`MEM_HIW-1:0] rdAddrHi,         // Read block select
  output logic [`MEM_DW-1:0]       rdData,           // Read data
  output logic                     rdValid,          // Read data valid
  output logic                     parityErr,        // Parity mismatch
  output logic                     fifoEmpty,        // Queue empty
  output logic                     fifoFull,         // Queue full
  output logic                     fifoAlmostEmpty,  // Queue almost empty
  output logic                     fifoAlmostFull,   // Queue almost full
  output logic                     irq               // Interrupt, active high
);
  mem_port_if memPort ();

  mem_block_pkg::mode_e  mode;
  logic [`CTRL_W-1:0]    ctrl_q;
  logic [`CTRL_W-1:0]    ctrl_d;
  logic [`MEM_AW-1:0]    depthM1_q;
  logic [`MEM_AW-1:0]    depthM1_d;
  logic [`MEM_AW-1:0]    aeLvl_q;
  logic [`MEM_AW-1:0]    aeLvl_d;
  logic [`MEM_AW-1:0]    afLvl_q;
  logic [`MEM_AW-1:0]    afLvl_d;
  logic [`MEM_DW-1:0]    colMask_q;
  logic [`MEM_DW-1:0]    colMask_d;
  logic [`IRQ_W-1:0]     irqStat_q;
  logic [`IRQ_W-1:0]     irqStat_d;
  logic [`IRQ_W-1:0]     irqMask_q;
  logic [`IRQ_W-1:0]     irqMask_d;
  logic [`IRQ_W-1:0]     irqClr;
  logic [`IRQ_W-1:0]     events;
  logic [31:0]           prdata_d;
  logic [31:0]           rdMux;
  logic                  pready_d;
  logic                  pslverr_d;
  logic                  irq_d;
  logic                  setup;
  logic                  access;
  logic                  hit;

  logic                  wrEnS_q;
  logic [`MEM_AW-1:0]    wrAddrS_q;
  logic [`MEM_HIW-1:0]   wrHiS_q;
  logic [`MEM_DW-1:0]    wrDataS_q;
  logic                  rdEnS_q;
  logic [`MEM_AW-1:0]    rdAddrS_q;
  logic [`MEM_HIW-1:0]   rdHiS_q;
  logic                  rdV1_q;
  logic [`MEM_DW-1:0]    pipeData_q;
  logic [`MEM_DW-1:0]    pipeData_d;
  logic                  pipeV_q;
  logic [`MEM_DW-1:0]    rdData_d;
  logic                  rdValid_d;
  logic                  parityErr_d;

  logic                  wEn;
  logic [`MEM_AW-1:0]    wA;
  logic [`MEM_HIW-1:0]   wHi;
  logic [`MEM_DW-1:0]    wD;
  logic                  rEn;
  logic [`MEM_AW-1:0]    rA;
  logic [`MEM_HIW-1:0]   rHi;
  logic [`MEM_HIW-1:0]   blockId;
  logic                  selW;
  logic                  selR;
  logic                  pipeOn;
  logic                  srcV;
  logic [`MEM_DW-1:0]    srcData;
  logic [`MEM_DW-1:0]    wordIn;
  logic                  push;
  logic                  pop;
  logic                  pushOk;
  logic                  popOk;
  logic [`MEM_AW-1:0]    wrPtr;
  logic [`MEM_AW-1:0]    rdPtr;
  logic [`CNT_W-1:0]     count;

  function automatic logic parity8(input logic [`MEM_AW-1:0] d, input logic odd);
    parity8 = (^d) ^ odd;
  endfunction

  assign mode    = ctrl_q[`CTRL_FIFO] ? mem_block_pkg::MODE_FIFO
                                      : mem_block_pkg::MODE_SRAM;
  assign blockId = ctrl_q[`CTRL_ID_HI:`CTRL_ID_LO];
  assign push    = (mode == mem_block_pkg::MODE_FIFO) & wEn;
  assign pop     = (mode == mem_block_pkg::MODE_FIFO) & rEn;

  fifo_level u_fifo (
    .clk         (sys_clk),
    .resetn      (resetn),
    .clear       (mode == mem_block_pkg::MODE_SRAM),
    .push        (push),
    .pop         (pop),
    .depthM1     (depthM1_q),
    .aeLvl       (aeLvl_q),
    .afLvl       (afLvl_q),
    .pushOk      (pushOk),
    .popOk       (popOk),
    .wrPtr       (wrPtr),
    .rdPtr       (rdPtr),
    .count       (count),
    .empty       (fifoEmpty),
    .full        (fifoFull),
    .almostEmpty (fifoAlmostEmpty),
    .almostFull  (fifoAlmostFull)
  );

  ram_256x9 u_ram (
    .clk    (sys_clk),
    .resetn (resetn),
    .port   (memPort)
  );

  // Port request selection and memory drive
  always_comb begin
    wEn = ctrl_q[`CTRL_WRSYNC] ? wrEnS_q   : wrEn;
    wA  = ctrl_q[`CTRL_WRSYNC] ? wrAddrS_q : wrAddr;
    wHi = ctrl_q[`CTRL_WRSYNC] ? wrHiS_q   : wrAddrHi;
    wD  = ctrl_q[`CTRL_WRSYNC] ? wrDataS_q : wrData;
    rEn = ctrl_q[`CTRL_RDSYNC] ? rdEnS_q   : rdEn;
    rA  = ctrl_q[`CTRL_RDSYNC] ? rdAddrS_q : rdAddr;
    rHi = ctrl_q[`CTRL_RDSYNC] ? rdHiS_q   : rdAddrHi;
    // In RAM mode, stacked blocks answer only to their own upper address
    selW = ~ctrl_q[`CTRL_CASC] | (wHi == blockId);
    selR = ~ctrl_q[`CTRL_CASC] | (rHi == blockId);
    wordIn = wD;
    if (ctrl_q[`CTRL_PAREN]) begin
      wordIn[`PAR_BIT] = parity8(wD[`MEM_AW-1:0], ctrl_q[`CTRL_PARODD]);
    end
    // Side-by-side blocks share addresses; unused columns store zero
    wordIn = wordIn & colMask_q;
    if (mode == mem_block_pkg::MODE_FIFO) begin
      memPort.wrEn   = pushOk;
      memPort.wrAddr = wrPtr;
      memPort.rdEn   = popOk;
      memPort.rdAddr = rdPtr;
    end else begin
      memPort.wrEn   = wEn & selW;
      memPort.wrAddr = wA;
      memPort.rdEn   = rEn & selR;
      memPort.rdAddr = rA;
    end
    memPort.wrData = wordIn;
  end

  // Read return path
  always_comb begin
    pipeOn      = ctrl_q[`CTRL_RDSYNC] & ctrl_q[`CTRL_RDPIPE];
    pipeData_d  = rdV1_q ? memPort.rdData : pipeData_q;
    srcV        = pipeOn ? pipeV_q : rdV1_q;
    srcData     = pipeOn ? pipeData_q : memPort.rdData;
    rdData_d    = srcV ? (srcData & colMask_q) : rdData;
    rdValid_d   = srcV;
    parityErr_d = srcV & ctrl_q[`CTRL_PAREN] &
                  (parity8(srcData[`MEM_AW-1:0], ctrl_q[`CTRL_PARODD]) !=
                   srcData[`PAR_BIT]);
  end

  // Single clock path, one memory access per port per cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrEnS_q    <= 1'b0;
      wrAddrS_q  <= '0;
      wrHiS_q    <= '0;
      wrDataS_q  <= '0;
      rdEnS_q    <= 1'b0;
      rdAddrS_q  <= '0;
      rdHiS_q    <= '0;
      rdV1_q     <= 1'b0;
      pipeData_q <= '0;
      pipeV_q    <= 1'b0;
      rdData     <= '0;
      rdValid    <= 1'b0;
      parityErr  <= 1'b0;
    end else begin
      wrEnS_q    <= wrEn;
      wrAddrS_q  <= wrAddr;
      wrHiS_q    <= wrAddrHi;
      wrDataS_q  <= wrData;
      rdEnS_q    <= rdEn;
      rdAddrS_q  <= rdAddr;
      rdHiS_q    <= rdAddrHi;
      rdV1_q     <= memPort.rdEn;
      pipeData_q <= pipeData_d;
      pipeV_q    <= rdV1_q;
      rdData     <= rdData_d;
      rdValid    <= rdValid_d;
      parityErr  <= parityErr_d;
    end
  end

  // Register file and interrupt status
  always_comb begin
    setup     = psel & ~penable;
    access    = psel & penable & pready;
    ctrl_d    = ctrl_q;
    depthM1_d = depthM1_q;
    aeLvl_d   = aeLvl_q;
    afLvl_d   = afLvl_q;
    colMask_d = colMask_q;
    irqMask_d = irqMask_q;
    irqClr    = '0;
    hit       = 1'b1;
    rdMux     = 32'h0000_0000;
    if (paddr == `REG_CTRL) begin
      rdMux = 32'(ctrl_q);
      if (access & pwrite) begin
        ctrl_d = pwdata[`CTRL_W-1:0] & `CTRL_WMASK;
      end
    end else if (paddr == `REG_DEPTH) begin
      rdMux = 32'(depthM1_q);
      if (access & pwrite) begin
        depthM1_d = pwdata[`MEM_AW-1:0];
      end
    end else if (paddr == `REG_THRESH) begin
      rdMux = 32'({afLvl_q, aeLvl_q});
      if (access & pwrite) begin
        aeLvl_d = pwdata[`MEM_AW-1:0];
        afLvl_d = pwdata[2*`MEM_AW-1:`MEM_AW];
      end
    end else if (paddr == `REG_COLMASK) begin
      rdMux = 32'(colMask_q);
      if (access & pwrite) begin
        colMask_d = pwdata[`MEM_DW-1:0];
      end
    end else if (paddr == `REG_STATUS) begin
      rdMux = 32'({fifoAlmostFull, fifoAlmostEmpty, fifoFull, fifoEmpty, count});
    end else if (paddr == `REG_IRQ_STAT) begin
      rdMux = 32'(irqStat_q);
      if (access & pwrite) begin
        irqClr = pwdata[`IRQ_W-1:0];
      end
    end else if (paddr == `REG_IRQ_MASK) begin
      rdMux = 32'(irqMask_q);
      if (access & pwrite) begin
        irqMask_d = pwdata[`IRQ_W-1:0];
      end
    end else begin
      hit = 1'b0;
    end
    events              = '0;
    events[`IRQ_PARITY] = parityErr_d;
    events[`IRQ_OVER]   = push & ~pushOk;
    events[`IRQ_UNDER]  = pop & ~popOk;
    // A new event outweighs a clear in the same cycle
    irqStat_d = (irqStat_q & ~irqClr) | events;
    irq_d     = |(irqStat_d & irqMask_d);
    pready_d  = setup;
    pslverr_d = setup & ~hit;
    prdata_d  = (setup & ~pwrite) ? rdMux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= `CTRL_RST;
      depthM1_q <= `DEPTH_RST;
      aeLvl_q   <= `AE_RST;
      afLvl_q   <= `AF_RST;
      colMask_q <= `COLMASK_RST;
      irqStat_q <= `IRQ_RST;
      irqMask_q <= `IRQ_RST;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq       <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      depthM1_q <= depthM1_d;
      aeLvl_q   <= aeLvl_d;
      afLvl_q   <= afLvl_d;
      colMask_q <= colMask_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      prdata    <= prdata_d;
      pready    <= pready_d;
      pslverr   <= pslverr_d;
      irq       <= irq_d;
    end
  end
endmodule
`default_nettype wire

// *** mem_block_checker.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mem_block_checker (
  input wire logic               sys_clk,          // Clock
  input wire logic               resetn,           // Reset
  input wire logic               psel,             // Bus select
  input wire logic               penable,          // Bus enable
  input wire logic               pwrite,           // Bus direction
  input wire logic [`APB_AW-1:0] paddr,            // Bus address
  input wire logic [31:0]        pwdata,           // Bus data
  input wire logic               pready,           // Bus ready
  input wire logic               wrEn,             // Write
  input wire logic               rdEn,             // Read
  input wire logic [`MEM_DW-1:0] rdData,           // Read data
  input wire logic               rdValid,          // Read valid
  input wire logic               parityErr,        // Parity
  input wire logic               fifoEmpty,        // Flag
  input wire logic               fifoFull,         // Flag
  input wire logic               fifoAlmostEmpty,  // Flag
  input wire logic               irq               // Interrupt
);
  logic [`CTRL_W-1:0] ctl_q, ctl_d;
  logic [`IRQ_W-1:0]  msk_q, msk_d;
  logic               acc, sr, pushFull, popEmpty;
  assign acc = psel && penable && pready && pwrite;
  assign sr = !ctl_q[`CTRL_FIFO] && !ctl_q[`CTRL_CASC];
  assign pushFull = wrEn && !rdEn && fifoFull && ctl_q[`CTRL_FIFO] && !ctl_q[`CTRL_WRSYNC];
  assign popEmpty = rdEn && !wrEn && fifoEmpty && ctl_q[`CTRL_FIFO] && !ctl_q[`CTRL_RDSYNC];
  // Shadow of mode and mask, seen from the bus
  always_comb begin
    ctl_d = ctl_q;
    msk_d = msk_q;
    if (acc && paddr == `REG_CTRL) ctl_d = pwdata[`CTRL_W-1:0] & `CTRL_WMASK;
    if (acc && paddr == `REG_IRQ_MASK) msk_d = pwdata[`IRQ_W-1:0];
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= `CTRL_RST;
      msk_q <= `IRQ_RST;
    end else begin
      ctl_q <= ctl_d;
      msk_q <= msk_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_rdAsync; rdEn && sr && !ctl_q[`CTRL_RDSYNC]; endsequence
  sequence s_rdSync; rdEn && sr && ctl_q[`CTRL_RDSYNC] && !ctl_q[`CTRL_RDPIPE]; endsequence
  sequence s_rdPipe; rdEn && sr && ctl_q[`CTRL_RDSYNC] && ctl_q[`CTRL_RDPIPE]; endsequence
  sequence s_setup; psel && !penable; endsequence
  a_async_rd_lat: assert property (s_rdAsync |-> ##2 rdValid)
    else $error("async read latency");
  a_sync_rd_lat: assert property (s_rdSync |-> ##3 rdValid)
    else $error("transparent read latency");
  a_pipe_rd_lat: assert property (s_rdPipe |-> ##4 rdValid)
    else $error("pipelined read latency");
  a_bus_one_wait: assert property (s_setup |=> pready ##1 !pready)
    else $error("bus ready timing");
  a_perr_valid: assert property (parityErr |-> rdValid)
    else $error("parity error without data");
  a_perr_value: assert property (rdValid && ctl_q[`CTRL_PAREN]
    |-> parityErr == ((^rdData) ^ ctl_q[`CTRL_PARODD]))
    else $error("parity check wrong");
  a_full_holds: assert property (pushFull |=> fifoFull)
    else $error("refused push changed level");
  a_over_irq: assert property (pushFull && msk_q[`IRQ_OVER] |=> irq)
    else $error("overflow not signalled");
  a_under_irq: assert property (popEmpty && msk_q[`IRQ_UNDER] |=> irq)
    else $error("underflow not signalled");
  a_empty_nodata: assert property (popEmpty |-> ##2 !rdValid)
    else $error("data from empty queue");
  a_empty_flags: assert property (fifoEmpty |-> fifoAlmostEmpty && !fifoFull)
    else $error("flag conflict");
endmodule
`default_nettype wire

// *** mem_user.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mem_user (
  input  wire logic               sys_clk,    // Clock
  output logic                    wrEn,       // Write request
  output logic [`MEM_AW-1:0]      wrAddr,     // Write address
  output logic [`MEM_HIW-1:0]     wrAddrHi,   // Write block
  output logic [`MEM_DW-1:0]      wrData,     // Write data
  output logic                    rdEn,       // Read request
  output logic [`MEM_AW-1:0]      rdAddr,     // Read address
  output logic [`MEM_HIW-1:0]     rdAddrHi,   // Read block
  input  wire logic [`MEM_DW-1:0] rdData,     // Read data
  input  wire logic               rdValid,    // Read valid
  input  wire logic               parityErr   // Parity
);
  logic [9:0] got[$];
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    {wrAddr, wrAddrHi, wrData, rdAddr, rdAddrHi} = '0;
  end
  // One word per edge at most, single write port
  task automatic wr(input int n, input logic [7:0] a, input logic [8:0] d, input logic [4:0] h);
    for (int i = 0; i < n; i++) begin
      wrEn <= 1'b1;
      wrAddr <= 8'(a + i);
      wrData <= 9'(d + i);
      wrAddrHi <= h;
      @(posedge sys_clk);
    end
    wrEn <= 1'b0;
    // Released word address and data lines show the inverse of the last value; the block select keeps its value
    wrAddr <= ~8'(a + n - 1);
    wrData <= ~9'(d + n - 1);
  endtask
  task automatic rd(input int n, input logic [7:0] a, input logic [4:0] h);
    for (int i = 0; i < n; i++) begin
      rdEn <= 1'b1;
      rdAddr <= 8'(a + i);
      rdAddrHi <= h;
      @(posedge sys_clk);
    end
    rdEn <= 1'b0;
    rdAddr <= ~8'(a + n - 1);
  endtask
  always @(posedge sys_clk) if (rdValid === 1'b1) got.push_back({parityErr, rdData});
endmodule
`default_nettype wire

// *** mem_block_tb.sv ***
`include "mem_block_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin \
  total_checks++; \
  if ((g) !== (x)) begin \
    n_fail++; \
    $display("BAD %0t mismatch got %h exp %h", $time, g, x); \
  end \
end
module mem_block_tb;
  logic                sys_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic                wrEn, rdEn, rdValid, parityErr;
  logic                fifoEmpty, fifoFull, fifoAlmostEmpty, fifoAlmostFull;
  logic [`APB_AW-1:0]  paddr;
  logic [31:0]         pwdata, prdata, r;
  logic [`MEM_AW-1:0]  wrAddr, rdAddr;
  logic [`MEM_HIW-1:0] wrAddrHi, rdAddrHi;
  logic [`MEM_DW-1:0]  wrData, rdData;
  int                  n_fail, total_checks;
  mem_block i_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wrEn, .wrAddr, .wrAddrHi, .wrData, .rdEn, .rdAddr, .rdAddrHi, .rdData,
    .rdValid, .parityErr, .fifoEmpty, .fifoFull, .fifoAlmostEmpty, .fifoAlmostFull, .irq);
  mem_user i_user (.sys_clk, .wrEn, .wrAddr, .wrAddrHi, .wrData, .rdEn, .rdAddr, .rdAddrHi,
    .rdData, .rdValid, .parityErr);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    @(posedge sys_clk);
  endtask
  task wrc(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask
  task gotc(input logic [9:0] x);
    logic [9:0] g;
    g = 'x;
    if (i_user.got.size() > 0) g = i_user.got.pop_front();
    `CHK(g, x)
  endtask
  task t_regs;
    rdc(`REG_CTRL, 32'h0);
    rdc(`REG_DEPTH, 32'hFF);
    rdc(`REG_THRESH, 32'hFF01);
    rdc(`REG_COLMASK, 32'h1FF);
    rdc(`REG_STATUS, 32'hA00);
    rdc(`REG_IRQ_STAT, 32'h0);
    rdc(`REG_IRQ_MASK, 32'h0);
    apb(1'b0, 12'h01C, 32'h0);
    `CHK({e, r}, 33'h100000000)
    wrc(`REG_CTRL, 32'hFFFFFFFF);
    rdc(`REG_CTRL, 32'h1F7F);
    wrc(`REG_CTRL, 32'h0);
    $display("t_regs done");
  endtask
  task t_sram;
    i_user.wr(256, 8'h00, 9'h0A5, 5'h00);
    i_user.rd(256, 8'h00, 5'h00);
    waitc(6);
    for (int i = 0; i < 256; i++) gotc({1'b0, 9'(9'h0A5 + i)});
    fork
      i_user.wr(1, 8'h10, 9'h1FF, 5'h00);
      i_user.rd(1, 8'h10, 5'h00);
    join
    waitc(1);
    i_user.rd(1, 8'h10, 5'h00);
    waitc(6);
    gotc(10'h0B5);
    gotc(10'h1FF);
    wrc(`REG_COLMASK, 32'h0FF);
    i_user.rd(1, 8'h10, 5'h00);
    waitc(6);
    gotc(10'h0FF);
    wrc(`REG_COLMASK, 32'h1FF);
    $display("t_sram done");
  endtask
  task t_sync;
    logic [3:0] cfg [4];
    cfg = '{4'h2, 4'h4, 4'h6, 4'hE};
    for (int k = 0; k < 4; k++) begin
      wrc(`REG_CTRL, {28'h0, cfg[k]});
      i_user.wr(2, 8'h20, 9'(9'h120 + 2 * k), 5'h00);
      waitc(2);
      i_user.rd(2, 8'h20, 5'h00);
      waitc(6);
      gotc({1'b0, 9'(9'h120 + 2 * k)});
      gotc({1'b0, 9'(9'h121 + 2 * k)});
    end
    wrc(`REG_CTRL, 32'h0);
    $display("t_sync done");
  endtask
  task t_parity;
    i_user.wr(2, 8'h30, 9'h002, 5'h00);
    wrc(`REG_CTRL, 32'h10);
    i_user.wr(1, 8'h32, 9'h007, 5'h00);
    i_user.rd(3, 8'h30, 5'h00);
    waitc(6);
    gotc(10'h202);
    gotc(10'h003);
    gotc(10'h107);
    rdc(`REG_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    wrc(`REG_IRQ_MASK, 32'h1);
    waitc(2);
    `CHK(irq, 1'b1)
    wrc(`REG_IRQ_STAT, 32'h1);
    waitc(2);
    `CHK(irq, 1'b0)
    wrc(`REG_CTRL, 32'h30);
    i_user.wr(1, 8'h33, 9'h007, 5'h00);
    i_user.rd(1, 8'h33, 5'h00);
    waitc(6);
    gotc(10'h007);
    wrc(`REG_CTRL, 32'h0);
    $display("t_parity done");
  endtask
  task t_fifo;
    wrc(`REG_CTRL, 32'h1);
    wrc(`REG_DEPTH, 32'h3);
    wrc(`REG_THRESH, 32'h0301);
    wrc(`REG_IRQ_MASK, 32'h6);
    i_user.wr(5, 8'h00, 9'h050, 5'h00);
    waitc(2);
    `CHK({fifoEmpty, fifoFull, fifoAlmostFull}, 3'b011)
    rdc(`REG_STATUS, 32'h1404);
    rdc(`REG_IRQ_STAT, 32'h2);
    `CHK(irq, 1'b1)
    wrc(`REG_IRQ_STAT, 32'h2);
    i_user.rd(5, 8'h00, 5'h00);
    waitc(6);
    for (int i = 0; i < 4; i++) gotc({1'b0, 9'(9'h050 + i)});
    `CHK(i_user.got.size(), 0)
    rdc(`REG_STATUS, 32'hA00);
    rdc(`REG_IRQ_STAT, 32'h4);
    wrc(`REG_IRQ_STAT, 32'h6);
    wrc(`REG_CTRL, 32'h0);
    $display("t_fifo done");
  endtask
  task t_casc;
    wrc(`REG_CTRL, 32'h340);
    i_user.wr(1, 8'h40, 9'h0AA, 5'h03);
    waitc(1);
    i_user.wr(1, 8'h40, 9'h155, 5'h04);
    i_user.rd(1, 8'h40, 5'h04);
    waitc(1);
    i_user.rd(1, 8'h40, 5'h03);
    waitc(6);
    gotc(10'h0AA);
    `CHK(i_user.got.size(), 0)
    wrc(`REG_CTRL, 32'h0);
    $display("t_casc done");
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    total_checks = 0;
    resetn = 1'b0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_sram();
    t_sync();
    t_parity();
    t_fifo();
    t_casc();
    conclude();
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
bind mem_block mem_block_checker i_chk (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .wrEn, .rdEn, .rdData, .rdValid, .parityErr, .fifoEmpty, .fifoFull,
  .fifoAlmostEmpty, .irq);
`default_nettype wire
